/* common/e3ai_pkg.sv */
// constants and types for the receive alarm interrupt block
// Operation
// - Alarm indication is declared when two consecutive received frames hold seven or fewer zeros in total.
// - A declared alarm indication clears once two consecutive frames each hold eight or more zeros.
// - The alarm-change interrupt, when enabled, fires both on declaration and on clearing.
// - Enable register bit 0 gates the alarm-change interrupt, one enabling and zero disabling it.
// - An alarm-change interrupt drives the interrupt request output low.
// - An alarm-change interrupt sets status register bit 0.
// - The present alarm state reads as a read-only flag at bit 3 of the configuration and status register.
// - The block never sends or clears the far-end failure indication on its own.
// - Out-of-frame is declared after four consecutive frames with errored alignment patterns.
// - While out-of-frame the previous alignment stays in use for payload until a new one is acquired.
// - The alignment-change interrupt, when enabled, fires when sync is regained at a different alignment.
// - Enable register bit 4 gates the alignment-change interrupt.
// - An alignment-change interrupt drives the interrupt request output low.
// - An alignment-change interrupt sets status register bit 4.
// - An alignment change normally comes with an out-of-frame change, so both may be pending at once.
package e3ai_pkg;
    // register map
    localparam logic [7:0] E3AI_ADDR_CFG_STAT = 8'h11;
    localparam logic [7:0] E3AI_ADDR_IRQ_EN   = 8'h12;
    localparam logic [7:0] E3AI_ADDR_IRQ_STAT = 8'h14;
    // field positions
    localparam int E3AI_BIT_FAR_END_RECEIVE_FAILURE_STATE = 0;
    localparam int E3AI_BIT_AIS_STATE  = 3;
    localparam int E3AI_BIT_OOF_STATE  = 5;
    localparam int E3AI_BIT_IRQ_AIS    = 0;
    localparam int E3AI_BIT_IRQ_OOF    = 3;
    localparam int E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE   = 4;
    // writable bits and reset values
    localparam logic [7:0] E3AI_CFG_WMASK  = 8'h80;
    localparam logic [7:0] E3AI_EN_WMASK   = 8'h1F;
    localparam logic [7:0] E3AI_STAT_MASK  = 8'h19;
    localparam logic [7:0] E3AI_RESET_BYTE = 8'h00;
    // detection thresholds
    localparam int E3AI_AIS_DECL_MAX = 7;
    localparam int E3AI_AIS_CLR_MIN  = 8;
    localparam int E3AI_OOF_FRAMES   = 4;
    localparam int E3AI_ZCNT_W       = 4;
    localparam int E3AI_OFFSET_W     = 11;

    typedef enum logic {E3AI_AIS_CLEAR, E3AI_AIS_ALARM} e3ai_ais_state_t;
    typedef enum logic {E3AI_IN_FRAME, E3AI_OUT_OF_FRAME} e3ai_frm_state_t;
endpackage

/* rtl/e3ai_ais_det.sv */
// zero counting alarm indication detector
`timescale 1ns/1ns
`default_nettype none
module e3ai_ais_det
    import e3ai_pkg::*;
#(
    parameter int ZW = E3AI_ZCNT_W
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bit_tick,
    input  wire logic bit_val,
    input  wire logic frame_tick,
    output var  logic ais,
    output var  logic ais_change
);
    e3ai_ais_state_t state;
    logic [ZW-1:0]   zcnt;
    logic [ZW-1:0]   prev_cnt;
    logic [ZW:0]     pair_sum;
    logic            zero_now;
    logic [ZW-1:0]   next_zcnt;
    logic            decl_hit;
    logic            clr_hit;

    // a zero in the cycle of the frame tick opens the next frame
    assign zero_now  = bit_tick && !bit_val;
    assign next_zcnt = (&zcnt) ? zcnt : zcnt + ZW'(1);  // saturate, only small counts matter
    assign pair_sum  = {1'b0, prev_cnt} + {1'b0, zcnt};
    assign decl_hit  = frame_tick && (pair_sum <= (ZW+1)'(E3AI_AIS_DECL_MAX));
    assign clr_hit   = frame_tick && (prev_cnt >= ZW'(E3AI_AIS_CLR_MIN))
                       && (zcnt >= ZW'(E3AI_AIS_CLR_MIN));

    // per-frame zero count and the previous frame's count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zcnt     <= '0;
            prev_cnt <= '1;
        end else if (frame_tick) begin
            prev_cnt <= zcnt;
            zcnt     <= zero_now ? ZW'(1) : '0;
        end else if (zero_now) begin
            zcnt <= next_zcnt;
        end
    end

    // alarm state, one change pulse per transition
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= E3AI_AIS_CLEAR;
            ais_change <= 1'b0;
        end else begin
            ais_change <= 1'b0;
            case (state)
                E3AI_AIS_CLEAR: if (decl_hit) begin
                    state      <= E3AI_AIS_ALARM;
                    ais_change <= 1'b1;
                end
                E3AI_AIS_ALARM: if (clr_hit) begin
                    state      <= E3AI_AIS_CLEAR;
                    ais_change <= 1'b1;
                end
                default: state <= E3AI_AIS_CLEAR;
            endcase
        end
    end
    assign ais = (state == E3AI_AIS_ALARM);

    ais_declare_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ais) |-> $past(frame_tick) && ($past(pair_sum) <= E3AI_AIS_DECL_MAX))
        else $error("alarm declared without a quiet frame pair");
    ais_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(ais) |-> $past(frame_tick) && ($past(prev_cnt) >= E3AI_AIS_CLR_MIN)
            && ($past(zcnt) >= E3AI_AIS_CLR_MIN))
        else $error("alarm cleared without two busy frames");
endmodule // e3ai_ais_det
`default_nettype wire

/* rtl/e3ai_frame_align.sv */
// out-of-frame tracking and alignment change detection
`timescale 1ns/1ns
`default_nettype none
module e3ai_frame_align
    import e3ai_pkg::*;
#(
    parameter int OW = E3AI_OFFSET_W
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          frame_tick,
    input  wire logic          fas_err,
    input  wire logic          resync,
    input  wire logic [OW-1:0] resync_offset,
    output var  logic          out_of_frame,
    output var  logic [OW-1:0] align_offset,
    output var  logic          oof_change,
    output var  logic          align_change
);
    e3ai_frm_state_t state;
    logic [2:0]      err_cnt;
    logic            err_frame;
    logic            oof_hit;

    assign err_frame = frame_tick && fas_err;
    assign oof_hit   = err_frame && (err_cnt == 3'(E3AI_OOF_FRAMES - 1));

    // errored frame run, alignment and change pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state        <= E3AI_IN_FRAME;
            err_cnt      <= '0;
            align_offset <= '0;
            oof_change   <= 1'b0;
            align_change <= 1'b0;
        end else begin
            oof_change   <= 1'b0;
            align_change <= 1'b0;
            case (state)
                E3AI_IN_FRAME: begin
                    if (oof_hit) begin
                        state      <= E3AI_OUT_OF_FRAME;
                        oof_change <= 1'b1;
                        err_cnt    <= '0;
                    end else if (frame_tick) begin
                        err_cnt <= fas_err ? err_cnt + 3'd1 : '0;
                    end
                end
                // old alignment kept for payload until a new one is found
                E3AI_OUT_OF_FRAME: if (resync) begin
                    state        <= E3AI_IN_FRAME;
                    oof_change   <= 1'b1;
                    align_offset <= resync_offset;
                    align_change <= (resync_offset != align_offset);
                end
                default: state <= E3AI_IN_FRAME;
            endcase
        end
    end
    assign out_of_frame = (state == E3AI_OUT_OF_FRAME);

    oof_declare_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(out_of_frame) |-> $past(fas_err) && $past(frame_tick) && ($past(err_cnt) == 3))
        else $error("out of frame without four errored frames");
    offset_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_of_frame && !resync) |=> $stable(align_offset))
        else $error("alignment moved while out of frame");
    framing_alignment_change_detect_a: assert property (@(posedge clk) disable iff (!rst_n)
        (out_of_frame && resync && (resync_offset != align_offset)) |=> align_change && oof_change)
        else $error("alignment change not flagged");
endmodule // e3ai_frame_align
`default_nettype wire

/* rtl/e3ai_top.sv */
// receive alarm and alignment change interrupt controller with register port
`timescale 1ns/1ns
`default_nettype none
module e3ai_top
    import e3ai_pkg::*;
#(
    parameter int OW = E3AI_OFFSET_W
) (
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    // register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output var  logic [7:0]    reg_rdata,
    // received stream from the line side
    input  wire logic          rx_bit_tick,
    input  wire logic          rx_bit,
    input  wire logic          rx_frame_tick,
    input  wire logic          rx_fas_err,
    input  wire logic          rx_resync,
    input  wire logic [OW-1:0] rx_resync_offset,
    input  wire logic          rx_far_end_fail,
    // results
    output var  logic [OW-1:0] rx_payload_offset,
    output var  logic          irq_n
);
    logic            rst_meta;
    logic            rst_n;
    logic            ais;
    logic            ais_change;
    logic            out_of_frame;
    logic            oof_change;
    logic            align_change;
    logic [OW-1:0]   align_offset;
    logic            far_end_receive_failure_state;
    logic [7:0]      cfg_bits;
    logic [7:0]      irq_en;
    logic [7:0]      irq_stat;
    logic [7:0]      ev_vec;
    logic [7:0]      set_vec;
    logic [7:0]      clr_vec;
    logic [7:0]      next_irq_stat;
    logic [7:0]      cfg_view;
    logic [7:0]      next_rdata;
    logic            wr_cfg;
    logic            wr_en;
    logic            wr_stat;
    logic            rd_cfg;
    logic            rd_en;
    logic            rd_stat;
    logic            next_irq_n;
    logic [7:0]      next_irq_en;

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    e3ai_ais_det u_ais (
        .clk        (sys_clk),
        .rst_n      (rst_n),
        .bit_tick   (rx_bit_tick),
        .bit_val    (rx_bit),
        .frame_tick (rx_frame_tick),
        .ais        (ais),
        .ais_change (ais_change)
    );

    e3ai_frame_align #(
        .OW (OW)
    ) u_align (
        .clk           (sys_clk),
        .rst_n         (rst_n),
        .frame_tick    (rx_frame_tick),
        .fas_err       (rx_fas_err),
        .resync        (rx_resync),
        .resync_offset (rx_resync_offset),
        .out_of_frame           (out_of_frame),
        .align_offset  (align_offset),
        .oof_change    (oof_change),
        .align_change  (align_change)
    );

    // payload extraction follows the held alignment, even while out of frame
    assign rx_payload_offset = align_offset;

    // far-end failure seen on the line is only reported, never acted upon
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            far_end_receive_failure_state <= 1'b0;
        end else begin
            far_end_receive_failure_state <= rx_far_end_fail;
        end
    end

    // address decode
    assign wr_cfg  = reg_wr && (reg_addr == E3AI_ADDR_CFG_STAT);
    assign wr_en   = reg_wr && (reg_addr == E3AI_ADDR_IRQ_EN);
    assign wr_stat = reg_wr && (reg_addr == E3AI_ADDR_IRQ_STAT);
    assign rd_cfg  = reg_rd && (reg_addr == E3AI_ADDR_CFG_STAT);
    assign rd_en   = reg_rd && (reg_addr == E3AI_ADDR_IRQ_EN);
    assign rd_stat = reg_rd && (reg_addr == E3AI_ADDR_IRQ_STAT);

    // writable configuration and enable bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_bits <= E3AI_RESET_BYTE;
            irq_en   <= E3AI_RESET_BYTE;
        end else begin
            if (wr_cfg) begin
                cfg_bits <= reg_wdata & E3AI_CFG_WMASK;
            end
            if (wr_en) begin
                irq_en <= reg_wdata & E3AI_EN_WMASK;
            end
        end
    end

    // events that set status only when their enable is on
    always_comb begin
        ev_vec                    = E3AI_RESET_BYTE;
        ev_vec[E3AI_BIT_IRQ_AIS]  = ais_change;
        ev_vec[E3AI_BIT_IRQ_OOF]  = oof_change;
        ev_vec[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE] = align_change;
    end
    assign set_vec = ev_vec & irq_en;

    // read clears, write of a one clears too; a new event wins over either
    assign clr_vec       = (rd_stat ? E3AI_STAT_MASK : E3AI_RESET_BYTE)
                           | (wr_stat ? reg_wdata : E3AI_RESET_BYTE);
    assign next_irq_stat = ((irq_stat & ~clr_vec) | set_vec) & E3AI_STAT_MASK;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= E3AI_RESET_BYTE;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    // active low request, low while an enabled status bit stands;
    // uses the enables as they stand after this edge, so disabling releases at once
    assign next_irq_en = wr_en ? (reg_wdata & E3AI_EN_WMASK) : irq_en;
    assign next_irq_n  = ~|(next_irq_stat & next_irq_en);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= next_irq_n;
        end
    end

    // live state flags; transmit side is left to software
    always_comb begin
        cfg_view                      = cfg_bits;
        cfg_view[E3AI_BIT_AIS_STATE]  = ais;
        cfg_view[E3AI_BIT_OOF_STATE]  = out_of_frame;
        cfg_view[E3AI_BIT_FAR_END_RECEIVE_FAILURE_STATE] = far_end_receive_failure_state;
    end

    // read mux, unmapped addresses read zero; status shows pre-clear value
    assign next_rdata = rd_cfg  ? cfg_view :
                        rd_en   ? irq_en :
                        rd_stat ? irq_stat :
                        E3AI_RESET_BYTE;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= E3AI_RESET_BYTE;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // checks on the interrupt path
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ais_irq_a: assert property (
        (ais_change && irq_en[E3AI_BIT_IRQ_AIS]) |=> irq_stat[E3AI_BIT_IRQ_AIS] && !irq_n)
        else $error("alarm change did not raise status and request");
    ais_gate_a: assert property (
        (!irq_en[E3AI_BIT_IRQ_AIS] && !irq_stat[E3AI_BIT_IRQ_AIS] && !wr_en)
            |=> !irq_stat[E3AI_BIT_IRQ_AIS])
        else $error("alarm status set while disabled");
    req_low_a: assert property (
        (set_vec != E3AI_RESET_BYTE) |=> !irq_n)
        else $error("request not low after enabled event");
    ais_status_a: assert property (
        (rd_stat && irq_stat[E3AI_BIT_IRQ_AIS] && !(|set_vec))
            |=> reg_rdata[E3AI_BIT_IRQ_AIS] && !irq_stat[E3AI_BIT_IRQ_AIS])
        else $error("alarm status not read as one then cleared");
    ais_flag_a: assert property (
        rd_cfg |=> reg_rdata[E3AI_BIT_AIS_STATE] == $past(ais))
        else $error("alarm state flag wrong on read");
    framing_alignment_change_gate_a: assert property (
        (!irq_en[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE] && !irq_stat[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE] && !wr_en)
            |=> !irq_stat[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE])
        else $error("alignment status set while disabled");
    framing_alignment_change_irq_a: assert property (
        (align_change && irq_en[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE]) |=> !irq_n)
        else $error("alignment change left request high");
    framing_alignment_change_status_a: assert property (
        (align_change && irq_en[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE]) |=> irq_stat[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE])
        else $error("alignment status not set");
    read_clear_a: assert property (
        (rd_stat && (set_vec == E3AI_RESET_BYTE)) |=> (irq_stat == E3AI_RESET_BYTE) && irq_n)
        else $error("status read did not clear and release request");
    req_release_a: assert property (
        ((irq_stat & irq_en) == E3AI_RESET_BYTE) |-> irq_n)
        else $error("request low with nothing pending");

    ais_decl_c: cover property ($rose(ais) ##[1:20] !irq_n);
    ais_clr_c: cover property ($fell(ais));
    both_pend_c: cover property (
        irq_stat[E3AI_BIT_IRQ_FRAMING_ALIGNMENT_CHANGE] && irq_stat[E3AI_BIT_IRQ_OOF]);
    rd_clear_c: cover property (!irq_n ##1 rd_stat ##1 irq_n);
endmodule // e3ai_top
`default_nettype wire

/* dv/e3ai_line_model.sv */
// line side model feeding received frames, realignments and far-end state
`timescale 1ns/1ns
`default_nettype none
module e3ai_line_model
    import e3ai_pkg::*;
#(
    parameter int OW         = E3AI_OFFSET_W,
    parameter int FRAME_BITS = 16
) (
    input  wire logic          clk,
    output var  logic          bit_tick,
    output var  logic          bit_val,
    output var  logic          frame_tick,
    output var  logic          fas_err,
    output var  logic          resync,
    output var  logic [OW-1:0] resync_offset,
    output var  logic          far_end_fail
);
    // quiet line until the bench asks for traffic
    initial begin
        bit_tick      = 1'b0;
        bit_val       = 1'b0;
        frame_tick    = 1'b0;
        fas_err       = 1'b0;
        resync        = 1'b0;
        resync_offset = '0;
        far_end_fail  = 1'b0;
    end

    // one frame, zeros first; idle lines flip so a stale value is never trusted
    task automatic frame(input int zeros, input logic err);
        for (int i = 0; i < FRAME_BITS; i++) begin
            @(posedge clk);
            bit_tick <= 1'b1;
            bit_val  <= (i >= zeros);
        end
        @(posedge clk);
        bit_tick   <= 1'b0;
        bit_val    <= ~bit_val;
        frame_tick <= 1'b1;
        fas_err    <= err;
        @(posedge clk);
        frame_tick <= 1'b0;
        fas_err    <= ~err;
    endtask

    // new alignment found by the hunt logic on the line side
    task automatic realign(input logic [OW-1:0] off);
        @(posedge clk);
        resync        <= 1'b1;
        resync_offset <= off;
        @(posedge clk);
        resync        <= 1'b0;
        resync_offset <= ~off;
    endtask

    // far-end failure bit level as received
    task automatic set_fef(input logic v);
        @(posedge clk);
        far_end_fail <= v;
    endtask
endmodule // e3ai_line_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the receive alarm interrupt block
`timescale 1ns/1ns
`default_nettype none
module testbench
    import e3ai_pkg::*;
;
    logic        sys_clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        rx_bit_tick;
    logic        rx_bit;
    logic        rx_frame_tick;
    logic        rx_fas_err;
    logic        rx_resync;
    logic [10:0] rx_resync_offset;
    logic        rx_far_end_fail;
    logic [10:0] rx_payload_offset;
    logic        irq_n;
    int          err_count;
    int          comparisons;
    // reference model state
    int          pz;
    int          ecnt;
    logic        m_ais;
    logic        m_oof;
    logic        m_fef;
    logic        m_cfg7;
    logic [10:0] m_off;
    logic [7:0]  m_stat;
    logic [7:0]  m_en;

    e3ai_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_bit_tick(rx_bit_tick), .rx_bit(rx_bit), .rx_frame_tick(rx_frame_tick),
        .rx_fas_err(rx_fas_err), .rx_resync(rx_resync), .rx_resync_offset(rx_resync_offset),
        .rx_far_end_fail(rx_far_end_fail), .rx_payload_offset(rx_payload_offset),
        .irq_n(irq_n));

    e3ai_line_model i_line (.clk(sys_clk), .bit_tick(rx_bit_tick), .bit_val(rx_bit),
        .frame_tick(rx_frame_tick), .fas_err(rx_fas_err), .resync(rx_resync),
        .resync_offset(rx_resync_offset), .far_end_fail(rx_far_end_fail));

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // register port master: one-cycle strobes, data the cycle after a read
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    // let events land, compare outputs, then clear status by read or write-one
    task automatic settle(input logic do_rd);
        logic [7:0] w;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("irq_n", {15'h0, ~|(m_stat & m_en & E3AI_STAT_MASK)}, {15'h0, irq_n});
        chk("payload offset", {5'h0, m_off}, {5'h0, rx_payload_offset});
        rchk(E3AI_ADDR_CFG_STAT, {m_cfg7, 1'b0, m_oof, 1'b0, m_ais, 2'b00, m_fef});
        w = 8'($urandom);
        if (do_rd || w[7]) begin
            rchk(E3AI_ADDR_IRQ_STAT, m_stat);
            m_stat = 8'h00;
        end else begin
            wr(E3AI_ADDR_IRQ_STAT, w);
            m_stat &= ~w;
        end
        repeat (2) @(posedge sys_clk);
        #1;
        chk("irq_n", {15'h0, ~|(m_stat & m_en & E3AI_STAT_MASK)}, {15'h0, irq_n});
    endtask

    // one received frame with the sliding two-frame zero window
    task automatic step(input int z, input logic err);
        i_line.frame(z, err);
        if (!m_ais && pz + z <= E3AI_AIS_DECL_MAX) begin
            m_ais = 1'b1;
            m_stat[0] |= m_en[0];
        end else if (m_ais && pz >= E3AI_AIS_CLR_MIN && z >= E3AI_AIS_CLR_MIN) begin
            m_ais = 1'b0;
            m_stat[0] |= m_en[0];
        end
        pz = z;
        ecnt = err ? ecnt + 1 : 0;
        if (ecnt >= E3AI_OOF_FRAMES && !m_oof) begin
            m_oof = 1'b1;
            m_stat[3] |= m_en[3];
        end
        settle(1'b0);
    endtask

    // new alignment only counts while out of frame
    task automatic realign(input logic [10:0] o);
        i_line.realign(o);
        if (m_oof) begin
            m_stat[3] |= m_en[3];
            m_stat[4] |= m_en[4] & (o != m_off);
            m_oof = 1'b0;
            m_off = o;
            ecnt = 0;
        end
        settle(1'b1);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under two thousand cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_count++;
        final_report();
    end

    // main sequence
    initial begin
        int zt[8];
        logic [7:0] w;
        zt = '{4, 3, 8, 8, 0, 7, 9, 8};
        sys_clk = 1'b0;
        reset_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        err_count = 0;
        comparisons = 0;
        pz = 15;
        ecnt = 0;
        m_ais = 1'b0;
        m_oof = 1'b0;
        m_fef = 1'b0;
        m_cfg7 = 1'b0;
        m_off = 11'h000;
        m_stat = 8'h00;
        m_en = 8'h00;
        void'($urandom(23885));
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rchk(E3AI_ADDR_CFG_STAT, 8'h00);
        rchk(E3AI_ADDR_IRQ_EN, 8'h00);
        rchk(E3AI_ADDR_IRQ_STAT, 8'h00);
        wr(8'h13, 8'hFF);
        rchk(8'h13, 8'h00);
        wr(E3AI_ADDR_CFG_STAT, 8'hFF);
        m_cfg7 = 1'b1;
        rchk(E3AI_ADDR_CFG_STAT, 8'h80);
        wr(E3AI_ADDR_IRQ_EN, 8'hFF);
        m_en = E3AI_EN_WMASK;
        rchk(E3AI_ADDR_IRQ_EN, 8'h1F);
        $display("test registers done");
        // threshold edges of the declare and clear windows
        foreach (zt[i]) step(zt[i], 1'b0);
        $display("test alarm thresholds done");
        // random counts, enables and far-end level
        for (int i = 0; i < 24; i++) begin
            w = 8'($urandom);
            if (w[1:0] == 2'b00) begin
                wr(E3AI_ADDR_IRQ_EN, w);
                m_en = w & E3AI_EN_WMASK;
                rchk(E3AI_ADDR_IRQ_EN, m_en);
            end
            m_fef = w[2];
            i_line.set_fef(m_fef);
            step($urandom_range(0, 12), 1'b0);
        end
        $display("test alarm random done");
        // out-of-frame and realignment; late resync in frame is ignored
        wr(E3AI_ADDR_IRQ_EN, 8'h19);
        m_en = 8'h19;
        realign(11'd99);
        repeat (4) step(10, 1'b1);
        step(10, 1'b0);
        realign(11'd0);
        repeat (4) step(10, 1'b1);
        realign(11'd37);
        wr(E3AI_ADDR_IRQ_EN, 8'h09);
        m_en = 8'h09;
        repeat (4) step(10, 1'b1);
        realign(11'd5);
        $display("test framing done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
